// [verilog/load_linked_execution.sv]
// Purpose: Execute linked word, user-space linked word and linked pair loads
// Assumes: Translation and memory answer on mem_ack; APB slave for control
// Notes: One instruction in flight; APB register-file access waits for idle
//   Every output is taken from the state register
//   Link flag is bit 0 of the link address
// Operation
// - Word linked load: major 011000, bits 15:12 0011, bits 11:9 000.
// - User-space linked load: major 011000, group 0110, bits 11:9 110.
// - Word loads add sign-extended 9-bit offset to base; older releases 16-bit.
// - Word load writes the fetched aligned 32-bit word unchanged to target.
// - Nonzero low two address bits raise address error.
// - At most one active read-modify-write sequence per processor.
// - Each linked load starts a new sequence replacing any older one.
// - Success sets link flag and link address; flag is its bit 0.
// - A linked load never forces remote conditional stores to fail.
// - Abandoning a sequence needs no completing instruction and is no error.
// - User-space load uses user mapping; other user-accessible modes also reachable.
// - User-space load exists only with enhanced addressing, needs coprocessor access.
// - Each load raises only its own listed exception kinds.
// - Pair load reads 64 bits; low word first dest, high word second.
// - Pair load is one double-word atomic access.
// - Pair load has no offset; base is the address.
// - Pair load leaves double-word aligned physical address in link register.
// - Cacheless operation allowed; link address register may then be dropped.
// - Pair load present only when pair disable reads 0, else reserved.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "linked_load_defines.svh"
module load_linked_execution (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  output logic issue_ready,
  output logic mem_req,
  output logic [31:0] mem_vaddr,
  output logic mem_user_map,
  output logic mem_pair,
  input wire logic mem_ack,
  input wire logic [31:0] mem_paddr,
  input wire logic [63:0] mem_rdata,
  input wire logic [1:0] mem_seg_mode,
  input wire logic mem_exc_valid,
  input wire logic [2:0] mem_exc,
  output logic done_valid,
  output logic [2:0] done_exc,
  input wire logic link_clear,
  output logic [31:0] link_address,
  output logic link_flag
);
  function automatic logic misaligned(input logic [31:0] a, input logic pair);
    if (pair)
    begin
      misaligned = a[2:0] != 3'h0;
    end
    else
    begin
      misaligned = a[1:0] != 2'h0;
    end
  endfunction

  function automatic logic [31:0] link_value(input logic [31:0] a);
    link_value = {a[31:1], 1'b1};
  endfunction

  // Registered state and its next value
  linked_load_pkg::core_state_type q;
  linked_load_pkg::core_state_type n;
  linked_load_pkg::decode_type dec;
  logic apb_access;
  logic in_gpr;
  logic is_pair;
  logic [31:0] ea;

  // General register file and its port
  gpr_port_if gpr ();

  gpr_file regs (
    .clock(clock),
    .nrst(nrst),
    .port(gpr)
  );

  // Instruction decoder
  linked_load_decode decoder (
    .instr(issue_instr),
    .cfg(q.cfg),
    .dec(dec)
  );

  // Register-file port
  assign gpr.rd_addr = n.rd_addr;
  assign gpr.we = q.we;
  assign gpr.wr_addr = q.wr_addr;
  assign gpr.wr_data = q.wr_data;

  // Bus access decode
  assign apb_access = psel && penable && !q.pready;
  assign in_gpr = paddr[`GPR_WINDOW_MSB:`GPR_WINDOW_LSB] == `GPR_WINDOW_TAG
                  && paddr[1:0] == 2'h0;
  assign is_pair = q.dec.op == linked_load_pkg::OP_LINKED_PAIR;
  // Effective address from the base register read
  assign ea = gpr.rd_data + q.dec.offset;

  // Next state of the whole unit
  always_comb
  begin
    n = q;
    n.done_valid = 1'b0;
    n.we = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    if (link_clear)
    begin
      n.link_addr[0] = 1'b0;
    end

    // Control and status registers answer in any phase
    if (apb_access && !in_gpr)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        `CTRL_OFFSET:
        begin
          n.prdata = {29'h0000_0000, q.cfg};
          if (pwrite)
          begin
            n.cfg = pwdata[2:0];
          end
        end

        `LINK_OFFSET:
        begin
          n.prdata = q.link_addr;
          if (pwrite)
          begin
            n.link_addr = pwdata;
          end
        end

        `STATUS_OFFSET:
        begin
          n.prdata = 32'h0000_0000;
          n.prdata[`STATUS_BUSY_BIT] = q.ph != linked_load_pkg::PH_IDLE;
          n.prdata[`STATUS_EXC_LSB +: 3] = q.last_exc;
        end

        default:
        begin
          n.pslverr = 1'b1;
        end
      endcase
    end

    // Instruction engine
    unique case (q.ph)
      linked_load_pkg::PH_IDLE:
      begin
        if (issue_valid && q.issue_ready)
        begin
          n.dec = dec;
          n.user_map = dec.op == linked_load_pkg::OP_LINKED_USER;
          n.pair = dec.op == linked_load_pkg::OP_LINKED_PAIR;
          if (dec.exc != linked_load_pkg::EXC_NONE)
          begin
            n.done_exc = dec.exc;
            n.done_valid = 1'b1;
            n.ph = linked_load_pkg::PH_DONE;
          end
          else
          begin
            n.rd_addr = dec.base;
            n.ph = linked_load_pkg::PH_READ_BASE;
          end
        end
        else if (apb_access && in_gpr && pwrite)
        begin
          n.we = 1'b1;
          n.wr_addr = paddr[6:2];
          n.wr_data = pwdata;
          n.pready = 1'b1;
        end
        else if (apb_access && in_gpr)
        begin
          n.rd_addr = paddr[6:2];
          n.ph = linked_load_pkg::PH_APB_READ;
        end
      end

      // Register-file read for the bus
      linked_load_pkg::PH_APB_READ:
      begin
        n.prdata = gpr.rd_data;
        n.pready = 1'b1;
        n.ph = linked_load_pkg::PH_IDLE;
      end

      // Effective address and alignment
      linked_load_pkg::PH_READ_BASE:
      begin
        n.vaddr = ea;
        if (misaligned(ea, is_pair))
        begin
          n.done_exc = linked_load_pkg::EXC_ADDRESS;
          n.done_valid = 1'b1;
          n.ph = linked_load_pkg::PH_DONE;
        end
        else
        begin
          n.mem_req = 1'b1;
          n.ph = linked_load_pkg::PH_TRANSLATE;
        end
      end

      // Wait for translation and data
      linked_load_pkg::PH_TRANSLATE:
      begin
        if (mem_ack)
        begin
          n.mem_req = 1'b0;
          if (mem_exc_valid)
          begin
            n.done_exc = linked_load_pkg::exc_type'(mem_exc);
            n.done_valid = 1'b1;
            n.ph = linked_load_pkg::PH_DONE;
          end
          else if (q.dec.op == linked_load_pkg::OP_LINKED_USER
                   && mem_seg_mode == linked_load_pkg::SEG_KERNEL_ONLY)
          begin
            n.done_exc = linked_load_pkg::EXC_ADDRESS;
            n.done_valid = 1'b1;
            n.ph = linked_load_pkg::PH_DONE;
          end
          else
          begin
            n.data = mem_rdata;
            if (is_pair)
            begin
              n.vaddr = {mem_paddr[31:3], 3'h0};
            end
            else
            begin
              n.vaddr = {mem_paddr[31:2], 2'h0};
            end
            n.we = q.dec.dest1 != 5'h00;
            n.wr_addr = q.dec.dest1;
            n.wr_data = mem_rdata[31:0];
            n.ph = linked_load_pkg::PH_WRITE_LOW;
          end
        end
      end

      // First destination written, link set for word loads
      linked_load_pkg::PH_WRITE_LOW:
      begin
        if (is_pair)
        begin
          n.we = q.dec.dest2 != 5'h00;
          n.wr_addr = q.dec.dest2;
          n.wr_data = q.data[63:32];
          n.ph = linked_load_pkg::PH_WRITE_HIGH;
        end
        else
        begin
          n.link_addr = link_value(q.vaddr);
          n.done_exc = linked_load_pkg::EXC_NONE;
          n.done_valid = 1'b1;
          n.ph = linked_load_pkg::PH_DONE;
        end
      end

      // Second destination written, link set
      linked_load_pkg::PH_WRITE_HIGH:
      begin
        n.link_addr = link_value(q.vaddr);
        n.done_exc = linked_load_pkg::EXC_NONE;
        n.done_valid = 1'b1;
        n.ph = linked_load_pkg::PH_DONE;
      end

      // Completion pulse
      linked_load_pkg::PH_DONE:
      begin
        n.last_exc = q.done_exc;
        n.ph = linked_load_pkg::PH_IDLE;
      end

      default:
      begin
        n.ph = linked_load_pkg::PH_IDLE;
      end
    endcase

    n.issue_ready = n.ph == linked_load_pkg::PH_IDLE;
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.ph <= linked_load_pkg::PH_IDLE;
      q.cfg <= `CTRL_RESET;
      q.link_addr <= `LINK_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  // Link state is local only: nothing here reaches other processors
  assign link_address = q.link_addr;
  assign link_flag = q.link_addr[0];
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign issue_ready = q.issue_ready;
  assign mem_req = q.mem_req;
  assign mem_vaddr = q.vaddr;
  assign mem_user_map = q.user_map;
  assign mem_pair = q.pair;
  assign done_valid = q.done_valid;
  assign done_exc = q.done_exc;
endmodule
`default_nettype wire

// [verilog/linked_load_defines.svh]
// Purpose: Offsets, field positions, codes and reset values of the linked load unit
// Assumes: 32-bit instruction words, APB register window of 4 KiB
// Notes: Definitions only
`ifndef LINKED_LOAD_DEFINES_SVH
`define LINKED_LOAD_DEFINES_SVH

// Instruction fields
`define MAJOR_MSB 31
`define MAJOR_LSB 26
`define DEST1_MSB 25
`define DEST1_LSB 21
`define BASE_MSB 20
`define BASE_LSB 16
`define GROUP_MSB 15
`define GROUP_LSB 12
`define SUB_MSB 11
`define SUB_LSB 9
`define OFFSET_MSB 8
`define OFFSET_LSB 0
`define DEST2_MSB 8
`define DEST2_LSB 4

// Opcode values
`define MAJOR_GROUP_C 6'h18
`define LINKED_LOAD_MINOR_CODE 4'h3
`define LINKED_WORD_SUB 3'h0
`define USER_SPACE_LOAD_GROUP 4'h6
`define LINKED_USER_SUB 3'h6
`define LINKED_PAIR_GROUP 4'h1
`define LINKED_PAIR_SUB 3'h0

// APB register offsets
`define CTRL_OFFSET 12'h000
`define LINK_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define GPR_WINDOW_TAG 5'h01
`define GPR_WINDOW_MSB 11
`define GPR_WINDOW_LSB 7

// Control fields
`define CTRL_EVA_BIT 0
`define CTRL_XNP_BIT 1
`define CTRL_COP_BIT 2
`define CTRL_RESET 3'h5
`define LINK_RESET 32'h0000_0000

// Status fields
`define STATUS_BUSY_BIT 0
`define STATUS_EXC_LSB 4

`endif

// [verilog/linked_load_pkg.sv]
// Purpose: Types shared by the linked load unit
// Assumes: Nothing
// Notes: Constants live in linked_load_defines.svh
package linked_load_pkg;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_ADDRESS = 3'h1,
    EXC_RESERVED = 3'h2,
    EXC_COP_UNUSABLE = 3'h3,
    EXC_TLB_REFILL = 3'h4,
    EXC_TLB_INVALID = 3'h5,
    EXC_WATCH = 3'h6
  } exc_type;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_LINKED_WORD = 2'h1,
    OP_LINKED_USER = 2'h2,
    OP_LINKED_PAIR = 2'h3
  } op_type;

  typedef enum logic [1:0] {
    SEG_MAPPED_USER_SUPER_UNMAPPED_KERNEL = 2'h0,
    SEG_UNMAPPED_ALL = 2'h1,
    SEG_MAPPED_USER_SUPER_KERNEL = 2'h2,
    SEG_KERNEL_ONLY = 2'h3
  } seg_mode_type;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_READ_BASE = 3'h1,
    PH_TRANSLATE = 3'h2,
    PH_WRITE_LOW = 3'h3,
    PH_WRITE_HIGH = 3'h4,
    PH_DONE = 3'h5,
    PH_APB_READ = 3'h6
  } phase_type;

  typedef struct packed {
    op_type op;
    exc_type exc;
    logic [4:0] dest1;
    logic [4:0] dest2;
    logic [4:0] base;
    logic [31:0] offset;
  } decode_type;

  typedef struct packed {
    phase_type ph;
    logic issue_ready;
    decode_type dec;
    logic [31:0] vaddr;
    logic [63:0] data;
    logic mem_req;
    logic done_valid;
    exc_type done_exc;
    exc_type last_exc;
    logic [31:0] link_addr;
    logic [2:0] cfg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [4:0] rd_addr;
    logic we;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    logic user_map;
    logic pair;
  } core_state_type;

endpackage

// [verilog/gpr_port_if.sv]
// Purpose: Read and write port of the general register file
// Assumes: Read data one clock after the address
// Notes: Owner drives, store answers
`timescale 1ns/1ps
`default_nettype none
interface gpr_port_if;
  logic [4:0] rd_addr;
  logic [31:0] rd_data;
  logic we;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  modport owner (output rd_addr, output we, output wr_addr, output wr_data, input rd_data);
  modport store (input rd_addr, input we, input wr_addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// [verilog/gpr_file.sv]
// Purpose: 32 general registers, one registered read port, one write port
// Assumes: Synchronous active-low reset clears only the read register
// Notes: Write to the same address as a read is bypassed
`timescale 1ns/1ps
`default_nettype none
module gpr_file (
  input wire logic clock,
  input wire logic nrst,
  gpr_port_if.store port
);
  logic [31:0] mem [32];
  logic [31:0] rd_q;

  assign port.rd_data = rd_q;

  always_ff @(posedge clock)
  begin
    if (port.we && port.wr_addr != 5'h00)
    begin
      mem[port.wr_addr] <= port.wr_data;
    end
    if (!nrst || port.rd_addr == 5'h00)
    begin
      rd_q <= 32'h0000_0000;
    end
    else if (port.we && port.wr_addr == port.rd_addr)
    begin
      rd_q <= port.wr_data;
    end
    else
    begin
      rd_q <= mem[port.rd_addr];
    end
  end
endmodule
`default_nettype wire

// [verilog/linked_load_decode.sv]
// Purpose: Recognise the linked load family and check availability
// Assumes: cfg bits as held in the control register
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "linked_load_defines.svh"
module linked_load_decode (
  input wire logic [31:0] instr,
  input wire logic [2:0] cfg,
  output linked_load_pkg::decode_type dec
);
  function automatic logic [31:0] sext9(input logic [8:0] v);
    sext9 = {{23{v[8]}}, v};
  endfunction

  logic [5:0] major;
  logic [3:0] group;
  logic [2:0] sub;

  assign major = instr[`MAJOR_MSB:`MAJOR_LSB];
  assign group = instr[`GROUP_MSB:`GROUP_LSB];
  assign sub = instr[`SUB_MSB:`SUB_LSB];

  always_comb
  begin
    dec.dest1 = instr[`DEST1_MSB:`DEST1_LSB];
    dec.dest2 = instr[`DEST2_MSB:`DEST2_LSB];
    dec.base = instr[`BASE_MSB:`BASE_LSB];
    dec.offset = sext9(instr[`OFFSET_MSB:`OFFSET_LSB]);
    dec.op = linked_load_pkg::OP_NONE;
    dec.exc = linked_load_pkg::EXC_RESERVED;
    if (major == `MAJOR_GROUP_C)
    begin
      if (group == `LINKED_LOAD_MINOR_CODE && sub == `LINKED_WORD_SUB)
      begin
        dec.op = linked_load_pkg::OP_LINKED_WORD;
        dec.exc = linked_load_pkg::EXC_NONE;
      end
      else if (group == `USER_SPACE_LOAD_GROUP && sub == `LINKED_USER_SUB)
      begin
        dec.op = linked_load_pkg::OP_LINKED_USER;
        if (!cfg[`CTRL_EVA_BIT])
        begin
          dec.exc = linked_load_pkg::EXC_RESERVED;
        end
        else if (!cfg[`CTRL_COP_BIT])
        begin
          dec.exc = linked_load_pkg::EXC_COP_UNUSABLE;
        end
        else
        begin
          dec.exc = linked_load_pkg::EXC_NONE;
        end
      end
      else if (group == `LINKED_PAIR_GROUP && sub == `LINKED_PAIR_SUB)
      begin
        dec.op = linked_load_pkg::OP_LINKED_PAIR;
        dec.offset = 32'h0000_0000;
        dec.exc = cfg[`CTRL_XNP_BIT] ? linked_load_pkg::EXC_RESERVED
                                     : linked_load_pkg::EXC_NONE;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/load_linked_execution_chk.sv]
// Purpose: Port assertions for the linked load unit
// Assumes: One memory request in flight
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module load_linked_execution_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic issue_ready,
  input wire logic mem_req,
  input wire logic [31:0] mem_vaddr,
  input wire logic mem_user_map,
  input wire logic mem_pair,
  input wire logic mem_ack,
  input wire logic [31:0] mem_paddr,
  input wire logic [1:0] mem_seg_mode,
  input wire logic mem_exc_valid,
  input wire logic [2:0] mem_exc,
  input wire logic done_valid,
  input wire logic [2:0] done_exc,
  input wire logic [31:0] link_address,
  input wire logic link_flag
);
  logic [31:0] ack_pa_q;
  always_ff @(posedge clock)
  begin
    if (mem_ack)
    begin
      ack_pa_q <= mem_paddr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_req_aligned: assert property (mem_req |-> mem_vaddr[1:0] == 2'b00)
    else $error("memory request at misaligned address");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_vaddr))
    else $error("memory request dropped early");
  a_one_flight: assert property (mem_req |-> !issue_ready)
    else $error("instruction offered while busy");
  a_flag_bit: assert property (done_valid && done_exc == 3'h0 |-> link_flag)
    else $error("link flag not set after a successful load");
  a_word_link: assert property (mem_ack && !mem_exc_valid && !mem_pair && mem_seg_mode != 2'h3 |-> ##2 (done_valid && done_exc == 3'h0 && link_address == {ack_pa_q[31:2], 2'b01}))
    else $error("word load link wrong");
  a_pair_link: assert property (mem_ack && !mem_exc_valid && mem_pair |-> ##3 (done_valid && done_exc == 3'h0 && link_address == {ack_pa_q[31:3], 3'b001}))
    else $error("pair load link wrong");
  a_mem_exc: assert property (mem_ack && mem_exc_valid |=> done_valid && done_exc == $past(mem_exc))
    else $error("memory exception not passed on");
  a_pair_aligned: assert property (mem_req && mem_pair |-> mem_vaddr[2:0] == 3'b000)
    else $error("pair request not double-word aligned");
  a_free_after: assert property (done_valid |=> issue_ready && !done_valid)
    else $error("not idle after completion");
endmodule
bind load_linked_execution load_linked_execution_chk i_load_linked_execution_chk (.clock, .nrst,
  .issue_ready, .mem_req, .mem_vaddr, .mem_user_map, .mem_pair, .mem_ack, .mem_paddr,
  .mem_seg_mode, .mem_exc_valid, .mem_exc, .done_valid, .done_exc, .link_address, .link_flag);
`default_nettype wire

// [verification/mem_model.sv]
// Purpose: Translation and memory stand-in
// Assumes: Identity translation, one request at a time
// Notes: Payload lines outside an answer show inverted values; mem_ack and mem_exc_valid stay low
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic [31:0] mem_vaddr,
  input wire logic mem_pair,
  input wire logic [1:0] delay,
  input wire logic [1:0] seg,
  input wire logic exc_en,
  input wire logic [2:0] exc_code,
  output logic mem_ack,
  output logic [31:0] mem_paddr,
  output logic [63:0] mem_rdata,
  output logic [1:0] mem_seg_mode,
  output logic mem_exc_valid,
  output logic [2:0] mem_exc
);
  logic [1:0] cnt;
  logic served;
  always @(posedge clock)
  begin
    mem_ack <= 1'b0;
    mem_exc_valid <= 1'b0;
    mem_paddr <= ~mem_paddr;
    mem_rdata <= ~mem_rdata;
    mem_seg_mode <= ~mem_seg_mode;
    mem_exc <= ~mem_exc;
    if (!nrst || !mem_req)
    begin
      cnt <= 2'h0;
      served <= 1'b0;
    end
    else if (!served && cnt == delay)
    begin
      mem_ack <= 1'b1;
      served <= 1'b1;
      mem_paddr <= mem_vaddr;
      mem_rdata <= {mem_pair ? ~mem_vaddr : mem_vaddr ^ 32'h3c3c_3c3c, mem_vaddr ^ 32'h3c3c_3c3c};
      mem_seg_mode <= seg;
      mem_exc_valid <= exc_en;
      mem_exc <= exc_code;
    end
    else if (!served)
    begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_load_linked_execution.sv]
// Purpose: Self-checking bench of the linked load unit
// Assumes: Register window at 0x080, control at 0x000
// Notes: Random loads from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb_load_linked_execution;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, issue_valid, issue_ready, mem_req, e;
  logic mem_user_map, mem_pair, mem_ack, mem_exc_valid, done_valid, link_clear, link_flag;
  logic exc_en, saw_req, saw_user, saw_pair;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, issue_instr, mem_vaddr, mem_paddr, link_address;
  logic [31:0] rnd, r, b, lk, saw_va;
  logic [63:0] mem_rdata;
  logic [1:0] mem_seg_mode, delay, seg;
  logic [2:0] mem_exc, done_exc, exc_code, ex;
  int num_errors, compares;
  always #25 clock = ~clock;
  load_linked_execution i_load_linked_execution (.clock, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_instr, .issue_ready,
    .mem_req, .mem_vaddr, .mem_user_map, .mem_pair, .mem_ack, .mem_paddr, .mem_rdata,
    .mem_seg_mode, .mem_exc_valid, .mem_exc, .done_valid, .done_exc, .link_clear,
    .link_address, .link_flag);
  mem_model i_mem_model (.clock, .nrst, .mem_req, .mem_vaddr, .mem_pair, .delay, .seg,
    .exc_en, .exc_code, .mem_ack, .mem_paddr, .mem_rdata, .mem_seg_mode, .mem_exc_valid,
    .mem_exc);
  always @(posedge clock)
    if (mem_req === 1'b1)
    begin
      saw_req <= 1'b1;
      saw_va <= mem_vaddr;
      saw_user <= mem_user_map;
      saw_pair <= mem_pair;
    end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] enc(input logic [3:0] g, input logic [2:0] s,
    input logic [4:0] rt, input logic [4:0] bs, input logic [8:0] low);
    return {6'h18, rt, bs, g, s, low};
  endfunction
  function automatic logic [11:0] ga(input logic [4:0] n);
    return {5'h01, n, 2'b00};
  endfunction
  task automatic report_and_stop;
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic run(input logic [31:0] ins, input logic [2:0] xex);
    saw_req = 1'b0;
    issue_valid <= 1'b1;
    issue_instr <= ins;
    do @(posedge clock); while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    do @(posedge clock); while (done_valid !== 1'b1);
    `CHK(done_exc, xex)
    `CHK(link_address, lk)
  endtask
  task automatic wtest(input logic [4:0] rt, input logic [4:0] bs, input logic [31:0] bv,
    input logic [8:0] off, input logic [2:0] xex, input logic usr);
    logic [31:0] ea;
    ea = bv + {{23{off[8]}}, off};
    apb(1'b1, ga(bs), bv);
    if (xex == 3'h0)
      lk = {ea[31:2], 2'b01};
    run(enc(usr ? 4'h6 : 4'h3, usr ? 3'h6 : 3'h0, rt, bs, off), xex);
    if (xex == 3'h0)
    begin
      apb(1'b0, ga(rt), 32'h0);
      `CHK(r, (rt == 5'd0) ? 32'h0 : ea ^ 32'h3c3c_3c3c)
      `CHK(saw_va, ea)
      `CHK(saw_user, usr)
    end
  endtask
  initial
  begin
    {psel, penable, pwrite, issue_valid, link_clear, exc_en} = 6'h00;
    {paddr, pwdata, issue_instr, delay, seg, exc_code} = '0;
    {num_errors, compares, lk} = '0;
    rnd = 32'hf912_f32c;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h0000_0005)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(e, 1'b1)
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      b = lfsr(rnd) & 32'hffff_fffc;
      delay <= rnd[1:0];
      seg <= i[0] ? i[2:1] : 2'h0;
      wtest(5'd17 + rnd[7:4], 5'd1 + rnd[11:8], b, {rnd[18:12], 2'b00},
        (i[0] && i[2:1] == 2'h3) ? 3'h1 : 3'h0, i[0]);
    end
    seg <= 2'h0;
    wtest(5'd2, 5'd1, 32'h0000_1000, 9'h1ff, 3'h1, 1'b0);
    `CHK(saw_req, 1'b0)
    wtest(5'd0, 5'd1, 32'h0000_2000, 9'h104, 3'h0, 1'b0);
    for (int c = 4; c < 7; c++)
    begin
      exc_en <= 1'b1;
      exc_code <= c[2:0];
      wtest(5'd2, 5'd1, 32'h0000_3000, 9'h008, c[2:0], 1'b0);
    end
    exc_en <= 1'b0;
    b = lfsr(rnd) & 32'hffff_fff8;
    apb(1'b1, ga(5'd6), b);
    lk = {b[31:3], 3'b001};
    run(enc(4'h1, 3'h0, 5'd3, 5'd6, {5'd4, 4'h0}), 3'h0);
    apb(1'b0, ga(5'd3), 32'h0);
    `CHK(r, b ^ 32'h3c3c_3c3c)
    apb(1'b0, ga(5'd4), 32'h0);
    `CHK(r, ~b)
    `CHK(saw_pair, 1'b1)
    link_clear <= 1'b1;
    @(posedge clock);
    link_clear <= 1'b0;
    @(posedge clock);
    lk[0] = 1'b0;
    `CHK(link_flag, 1'b0)
    apb(1'b1, 12'h000, 32'h0000_0004);
    run(enc(4'h6, 3'h6, 5'd2, 5'd1, 9'h0), 3'h2);
    apb(1'b1, 12'h000, 32'h0000_0001);
    run(enc(4'h6, 3'h6, 5'd2, 5'd1, 9'h0), 3'h3);
    apb(1'b1, 12'h000, 32'h0000_0007);
    run(enc(4'h1, 3'h0, 5'd3, 5'd6, 9'h040), 3'h2);
    report_and_stop;
  end
  initial
  begin
    #(30000 * 50);
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
